// >>> src/optical_exposure_sequencer.sv
// Purpose: exposure sequencing, sample tagging and result store
// Assumes: AFE answers convert_req with one adc_valid pulse
// Notes: two-wire port, GPIO and regulator enable sampled by mclk
// How it works
// [RULE1] Slots one to six stepped in order
// [RULE2] First none slot ends the sequence
// [RULE3] Codes one to three fire LED one-three
// [RULE4] Pilot on LED one, ambient with no LED
// [RULE5] Six nibbles in three bytes, reset zero
// [RULE6] Result store holds 128 entries
// [RULE7] Entries three bytes with five-bit tag
// [RULE8] Results pushed in slot order
// [RULE9] Picket fence pushes predicted value, own tag; code uses slot tags 4 to 6 for pickets in slots four to six
// [RULE10] Sample rate 8 to 4096 per second
// [RULE11] Low power only at 256 per second or less
// [RULE12] Pulse width 14.8 to 117.3 microseconds
// [RULE13] Per LED 8-bit current, four ranges
// [RULE14] Regulator enable low means shutdown
// [RULE15] GPIO output open-drain, only pulls low
// [RULE16] Host sync pulse held long enough low
// [RULE17] Tags one to six for slot results
// [RULE18] Tag in bits 23:19, data below
// [RULE19] Pilot results carry tag 11001
// [RULE20] Empty first slot: nothing exposed or pushed
`timescale 1ns/1ps
module optical_exposure_sequencer
	import oes_pkg::*;
#(
	parameter int RATE_PERIOD = RATE_PERIOD_MIN
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic gpio_i,
	output logic gpio_o,
	output logic gpio_oe,
	input wire logic regulator_enable_input,
	output logic [NUM_LEDS-1:0] led_on,
	output logic [7:0] led_current_code,
	output logic [RANGE_W-1:0] led_fullscale_range,
	output logic integrate,
	output logic pilot,
	output logic convert_req,
	output logic power_down,
	input wire logic adc_valid,
	input wire logic [DATA_W-1:0] adc_data,
	input wire logic adc_picket
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_NEXT = 3'h1, S_EXPOSE = 3'h3,
		S_CONVERT = 3'h2, S_PUSH = 3'h6
	} seq_e;
	typedef enum logic [3:0] {
		I_IDLE = 4'h0, I_ADDR = 4'h1, I_AACK = 4'h3, I_REG = 4'h2,
		I_RACK = 4'h6, I_WDATA = 4'h7, I_WACK = 4'h5,
		I_RDATA = 4'hB, I_RDACK = 4'h9
	} i2c_e;

	logic [3:0] pins;
	logic scl_s, sda_s, gpio_s, reg_on;
	logic scl_p_q, sda_p_q, gpio_p_q;
	pin_sync #(.N(4), .INIT(SYNC_INIT)) u_sync (
		.clk(mclk),
		.rst_n(resetn),
		.d({regulator_enable_input, gpio_i, sda_i, scl}),
		.q(pins)
	);
	assign {reg_on, gpio_s, sda_s, scl_s} = pins;

	// Result path: sequencer -> 8-word buffer -> 128-entry store
	logic push_q, push_d, buf_ready, mid_valid, mid_ready;
	logic [WORD_W-1:0] word_q, word_d, mid_word, store_word;
	logic store_valid, store_pop;
	logic [7:0] store_count;
	stream_fifo #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
		.clk(mclk),
		.rst_n(resetn),
		.in_valid(push_q),
		.in_ready(buf_ready),
		.in_data(word_q),
		.out_valid(mid_valid),
		.out_ready(mid_ready),
		.out_data(mid_word),
		.count()
	);
	stream_fifo #(.W(WORD_W), .DEPTH(STORE_DEPTH)) u_store ( // RULE6 RULE7
		.clk(mclk),
		.rst_n(resetn),
		.in_valid(mid_valid),
		.in_ready(mid_ready),
		.in_data(mid_word),
		.out_valid(store_valid),
		.out_ready(store_pop),
		.out_data(store_word),
		.count(store_count)
	);

	// Two-wire slave and register file
	i2c_e ist_q, ist_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, rd_byte;
	logic rw_q, rw_d, oe_q, oe_d;
	logic [1:0] rdb_q, rdb_d;
	logic [7:0] slots_q [3], slots_d [3], amp_q [3], amp_d [3];
	logic [7:0] cfg_q, cfg_d, gcfg_q, gcfg_d, range_q, range_d;
	logic scl_rise, scl_fall, start_c, stop_c, do_load, do_wr;
	logic [WORD_W-1:0] rd_word;
	seq_e st_q, st_d;
	logic pd_q;

	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign rd_word = store_valid ? store_word : {TAG_INVALID, DATA_W'(0)};

	always_comb begin
		case (ptr_q)
			A_COUNT: rd_byte = store_count;
			A_DATA: rd_byte = rd_word[(2 - rdb_q) * 8 +: 8];
			A_SAMPLE_CFG: rd_byte = cfg_q;
			A_GPIO_CFG: rd_byte = gcfg_q;
			A_STATUS: rd_byte = {5'h00, pd_q, st_q != S_IDLE, reg_on};
			A_SLOTS12: rd_byte = slots_q[0];
			A_SLOTS34: rd_byte = slots_q[1];
			A_SLOTS56: rd_byte = slots_q[2];
			A_LED_AMP1: rd_byte = amp_q[0];
			A_LED_AMP2: rd_byte = amp_q[1];
			A_LED_AMP3: rd_byte = amp_q[2];
			A_LED_RANGE: rd_byte = range_q;
			default: rd_byte = RST_BYTE;
		endcase
	end

	always_comb begin
		ist_d = ist_q;
		bit_d = bit_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		oe_d = oe_q;
		rdb_d = rdb_q;
		slots_d = slots_q;
		amp_d = amp_q;
		cfg_d = cfg_q;
		gcfg_d = gcfg_q;
		range_d = range_q;
		do_load = 1'b0;
		do_wr = 1'b0;
		store_pop = 1'b0;
		if (start_c) begin
			ist_d = I_ADDR;
			bit_d = '0;
			oe_d = 1'b0;
		end else if (stop_c) begin
			ist_d = I_IDLE;
			oe_d = 1'b0;
		end else if (scl_rise) begin
			if (ist_q inside {I_ADDR, I_REG, I_WDATA, I_RDACK})
				sh_d = {sh_q[6:0], sda_s};
			if (ist_q inside {I_ADDR, I_REG, I_WDATA, I_RDATA})
				bit_d = bit_q + 4'h1;
		end else if (scl_fall) begin
			case (ist_q)
				I_ADDR: if (bit_q == 4'h8) begin
					ist_d = (sh_q[7:1] == DEV_ADDR) ? I_AACK : I_IDLE;
					oe_d = (sh_q[7:1] == DEV_ADDR);
					rw_d = sh_q[0];
				end
				I_REG: if (bit_q == 4'h8) begin
					ptr_d = sh_q;
					rdb_d = '0;
					oe_d = 1'b1;
					ist_d = I_RACK;
				end
				I_WDATA: if (bit_q == 4'h8) begin
					do_wr = 1'b1;
					oe_d = 1'b1;
					ist_d = I_WACK;
					if (ptr_q != A_DATA)
						ptr_d = ptr_q + 8'h01;
				end
				I_AACK: begin
					oe_d = 1'b0;
					bit_d = '0;
					ist_d = I_REG;
					do_load = rw_q;
				end
				I_RACK, I_WACK: begin
					oe_d = 1'b0;
					bit_d = '0;
					ist_d = I_WDATA;
				end
				I_RDATA: if (bit_q == 4'h8) begin
					oe_d = 1'b0;
					ist_d = I_RDACK;
				end else begin
					oe_d = ~tx_q[6];
					tx_d = {tx_q[6:0], 1'b0};
				end
				I_RDACK: begin
					bit_d = '0;
					ist_d = I_IDLE;
					do_load = ~sh_q[0];
				end
				default: ist_d = I_IDLE;
			endcase
		end
		if (do_load) begin
			tx_d = rd_byte;
			oe_d = ~rd_byte[7];
			ist_d = I_RDATA;
			if (ptr_q == A_DATA) begin
				rdb_d = (rdb_q == 2'h2) ? 2'h0 : rdb_q + 2'h1;
				store_pop = (rdb_q == 2'h2) & store_valid;
			end else begin
				ptr_d = ptr_q + 8'h01;
			end
		end
		if (do_wr) begin
			case (ptr_q)
				A_SAMPLE_CFG: cfg_d = sh_q; // RULE10 RULE12
				A_GPIO_CFG: gcfg_d = sh_q;
				A_SLOTS12: slots_d[0] = sh_q; // RULE5
				A_SLOTS34: slots_d[1] = sh_q; // RULE5
				A_SLOTS56: slots_d[2] = sh_q; // RULE5
				A_LED_AMP1: amp_d[0] = sh_q; // RULE13
				A_LED_AMP2: amp_d[1] = sh_q; // RULE13
				A_LED_AMP3: amp_d[2] = sh_q; // RULE13
				A_LED_RANGE: range_d = sh_q; // RULE13
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ist_q <= I_IDLE;
			bit_q <= '0;
			sh_q <= RST_BYTE;
			tx_q <= RST_BYTE;
			ptr_q <= RST_BYTE;
			rw_q <= 1'b0;
			oe_q <= 1'b0;
			rdb_q <= '0;
			slots_q <= '{RST_BYTE, RST_BYTE, RST_BYTE};
			amp_q <= '{RST_BYTE, RST_BYTE, RST_BYTE};
			cfg_q <= RST_SAMPLE_CFG;
			gcfg_q <= RST_BYTE;
			range_q <= RST_BYTE;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			ist_q <= ist_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			oe_q <= oe_d;
			rdb_q <= rdb_d;
			slots_q <= slots_d;
			amp_q <= amp_d;
			cfg_q <= cfg_d;
			gcfg_q <= gcfg_d;
			range_q <= range_d;
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Sample timer, sync input, low power and GPIO output
	logic [TMR_W-1:0] tmr_q, tmr_d, period;
	logic [SR_W-1:0] sr;
	logic tick_q, tick_d, pd_d, goe_q, goe_d, lp_ok;

	always_comb begin
		sr = cfg_q[SR_LSB +: SR_W];
		if (sr < SR_MIN_CODE)
			sr = SR_MIN_CODE;
		else if (sr > SR_MAX_CODE)
			sr = SR_MAX_CODE;
		period = TMR_W'(RATE_PERIOD) >> (sr - SR_MIN_CODE); // RULE10
		lp_ok = cfg_q[LP_BIT] & (sr <= SR_LP_MAX_CODE);
		tmr_d = (tmr_q == '0) ? period - 1'b1 : tmr_q - 1'b1;
		tick_d = (tmr_q == '0);
		if (gcfg_q[1:0] == GPIO_SYNC)
			tick_d = gpio_p_q & ~gpio_s; // RULE16
		if (!reg_on) begin
			tmr_d = '0;
			tick_d = 1'b0;
		end
		pd_d = lp_ok & reg_on & (st_d == S_IDLE); // RULE11
		goe_d = (gcfg_q[1:0] == GPIO_OUT) & store_valid; // RULE15
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tmr_q <= '0;
			tick_q <= 1'b0;
			pd_q <= 1'b0;
			goe_q <= 1'b0;
			gpio_p_q <= 1'b1;
		end else begin
			tmr_q <= tmr_d;
			tick_q <= tick_d;
			pd_q <= pd_d;
			goe_q <= goe_d;
			gpio_p_q <= gpio_s;
		end
	end

	// Exposure sequencer
	logic [2:0] slot_q, slot_d;
	logic [3:0] code;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [NUM_LEDS-1:0] led_q, led_d;
	logic [7:0] cur_q, cur_d;
	logic [RANGE_W-1:0] rng_q, rng_d;
	logic integ_q, integ_d, pil_q, pil_d, conv_q, conv_d;
	logic [TAG_W-1:0] tag;
	logic [1:0] li;
	logic [4*NUM_SLOTS-1:0] slot_word;

	always_comb begin
		slot_word = {slots_q[2], slots_q[1], slots_q[0]};
		code = (slot_q < 3'(NUM_SLOTS)) ?
			slot_word[{slot_q, 2'b00} +: 4] : C_NONE;
		li = (code == C_LED2) ? 2'h1 : (code == C_LED3) ? 2'h2 : 2'h0;
		if (code == C_PILOT)
			tag = TAG_PILOT; // RULE19
		else if (adc_picket && slot_q < 3'(NUM_LEDS))
			tag = TAG_PICKET_BASE + TAG_W'(slot_q); // RULE9
		else
			tag = TAG_W'(slot_q) + 5'h01; // RULE17
		st_d = st_q;
		slot_d = slot_q;
		cnt_d = cnt_q;
		led_d = led_q;
		cur_d = cur_q;
		rng_d = rng_q;
		integ_d = integ_q;
		pil_d = pil_q;
		push_d = push_q;
		word_d = word_q;
		conv_d = 1'b0;
		case (st_q)
			S_IDLE: if (tick_q) begin
				slot_d = '0; // RULE1
				st_d = S_NEXT;
			end
			S_NEXT: if (code == C_NONE) begin
				st_d = S_IDLE; // RULE2 RULE20
			end else if (code inside {C_LED1, C_LED2, C_LED3, C_PILOT,
					C_AMBIENT}) begin
				st_d = S_EXPOSE;
				cnt_d = CNT_W'(ns_to_cyc(PW_NS[cfg_q[PW_LSB +: 2]])); // RULE12
				integ_d = 1'b1;
				pil_d = (code == C_PILOT); // RULE4
				led_d = (code == C_AMBIENT) ? '0 : // RULE4
					NUM_LEDS'(1) << li; // RULE3
				cur_d = amp_q[li]; // RULE13
				rng_d = range_q[li * RANGE_W +: RANGE_W]; // RULE13
			end else begin
				slot_d = slot_q + 3'h1;
			end
			S_EXPOSE: begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q <= CNT_W'(1)) begin
					integ_d = 1'b0;
					pil_d = 1'b0;
					led_d = '0;
					conv_d = 1'b1;
					st_d = S_CONVERT;
				end
			end
			S_CONVERT: if (adc_valid) begin
				word_d = {tag, adc_data}; // RULE18
				push_d = 1'b1;
				st_d = S_PUSH;
			end
			S_PUSH: if (buf_ready) begin
				push_d = 1'b0;
				slot_d = slot_q + 3'h1; // RULE8
				st_d = S_NEXT;
			end
			default: st_d = S_IDLE;
		endcase
		if (!reg_on) begin
			st_d = S_IDLE; // RULE14
			led_d = '0;
			integ_d = 1'b0;
			pil_d = 1'b0;
			push_d = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_q <= S_IDLE;
			slot_q <= '0;
			cnt_q <= '0;
			led_q <= '0;
			cur_q <= RST_BYTE;
			rng_q <= '0;
			integ_q <= 1'b0;
			pil_q <= 1'b0;
			conv_q <= 1'b0;
			push_q <= 1'b0;
			word_q <= '0;
		end else begin
			st_q <= st_d;
			slot_q <= slot_d;
			cnt_q <= cnt_d;
			led_q <= led_d;
			cur_q <= cur_d;
			rng_q <= rng_d;
			integ_q <= integ_d;
			pil_q <= pil_d;
			conv_q <= conv_d;
			push_q <= push_d;
			word_q <= word_d;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe = oe_q;
	assign gpio_o = 1'b0;
	assign gpio_oe = goe_q;
	assign led_on = led_q;
	assign led_current_code = cur_q;
	assign led_fullscale_range = rng_q;
	assign integrate = integ_q;
	assign pilot = pil_q;
	assign convert_req = conv_q;
	assign power_down = pd_q;

	a_slot_order: assert property ((st_q == S_PUSH && buf_ready && reg_on)
		|=> slot_q == $past(slot_q) + 3'h1) else $error("slot skip"); // RULE8
	a_none_ends: assert property ((st_q == S_NEXT && code == C_NONE)
		|=> st_q == S_IDLE) else $error("none did not end"); // RULE2
	a_first_none: assert property ((st_q == S_NEXT && slot_q == '0 &&
		code == C_NONE) |=> !integ_q ##1 !push_q)
		else $error("exposure on empty slot"); // RULE20
	a_led_select: assert property ((st_q == S_NEXT && code == C_LED2 &&
		reg_on) |=> led_q == 3'h2 && integ_q)
		else $error("wrong LED"); // RULE3
	a_ambient_dark: assert property ((integ_q && code == C_AMBIENT)
		|-> led_q == '0 && !pil_q) else $error("LED on ambient"); // RULE4
	a_pilot_tag: assert property ((push_q && code == C_PILOT)
		|-> word_q[WORD_W-1 -: TAG_W] == TAG_PILOT)
		else $error("pilot tag"); // RULE19
	a_slot_tag: assert property ((st_q == S_CONVERT && adc_valid &&
		!adc_picket && code == C_LED1 && reg_on)
		|=> word_q[WORD_W-1 -: TAG_W] == TAG_W'(slot_q) + 5'h01 &&
		word_q[DATA_W-1:0] == $past(adc_data))
		else $error("slot tag"); // RULE17
	a_picket_tag: assert property ((st_q == S_CONVERT && adc_valid &&
		adc_picket && slot_q == '0 && code != C_PILOT && reg_on)
		|=> word_q[WORD_W-1 -: TAG_W] == TAG_PICKET_BASE)
		else $error("picket tag"); // RULE9
	a_shutdown: assert property (!reg_on |=> st_q == S_IDLE && !integ_q)
		else $error("active in shutdown"); // RULE14
	a_low_power: assert property (pd_q |-> $past(sr) <= SR_LP_MAX_CODE)
		else $error("low power above limit"); // RULE11
	a_gpio_low: assert property (gpio_oe |-> gpio_o == 1'b0 &&
		$past(gcfg_q[1:0]) == GPIO_OUT) else $error("gpio"); // RULE15
endmodule

// >>> src/oes_pkg.sv
// Purpose: shared constants of the optical exposure sequencer
// Assumes: 100 MHz mclk
// Notes: register addresses are byte offsets on the two-wire port
package oes_pkg;
	localparam int CLK_MHZ = 100;
	localparam int CLK_HZ = CLK_MHZ * 1_000_000;
	localparam logic [6:0] DEV_ADDR = 7'h62;

	localparam logic [7:0] A_COUNT = 8'h07;
	localparam logic [7:0] A_DATA = 8'h08;
	localparam logic [7:0] A_SAMPLE_CFG = 8'h10;
	localparam logic [7:0] A_GPIO_CFG = 8'h11;
	localparam logic [7:0] A_STATUS = 8'h12;
	localparam logic [7:0] A_SLOTS12 = 8'h20;
	localparam logic [7:0] A_SLOTS34 = 8'h21;
	localparam logic [7:0] A_SLOTS56 = 8'h22;
	localparam logic [7:0] A_LED_AMP1 = 8'h23;
	localparam logic [7:0] A_LED_AMP2 = 8'h24;
	localparam logic [7:0] A_LED_AMP3 = 8'h25;
	localparam logic [7:0] A_LED_RANGE = 8'h26;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_SAMPLE_CFG = 8'h0A;

	localparam int SR_LSB = 0;
	localparam int SR_W = 5;
	localparam int PW_LSB = 5;
	localparam int LP_BIT = 7;
	localparam int RANGE_W = 2;
	localparam logic [4:0] SR_MIN_CODE = 5'h0A;
	localparam logic [4:0] SR_MAX_CODE = 5'h13;
	localparam logic [4:0] SR_LP_MAX_CODE = 5'h0F;
	localparam int MIN_RATE_SPS = 8;
	localparam int RATE_PERIOD_MIN = CLK_HZ / MIN_RATE_SPS;
	localparam int TMR_W = 24;

	localparam logic [1:0] GPIO_OFF = 2'h0;
	localparam logic [1:0] GPIO_OUT = 2'h1;
	localparam logic [1:0] GPIO_SYNC = 2'h2;

	localparam int NUM_SLOTS = 6;
	localparam int NUM_LEDS = 3;
	localparam logic [3:0] C_NONE = 4'h0;
	localparam logic [3:0] C_LED1 = 4'h1;
	localparam logic [3:0] C_LED2 = 4'h2;
	localparam logic [3:0] C_LED3 = 4'h3;
	localparam logic [3:0] C_PILOT = 4'h8;
	localparam logic [3:0] C_AMBIENT = 4'h9;

	localparam int TAG_W = 5;
	localparam int DATA_W = 19;
	localparam int WORD_W = 24;
	localparam logic [4:0] TAG_PICKET_BASE = 5'h0D;
	localparam logic [4:0] TAG_PILOT = 5'h19;
	localparam logic [4:0] TAG_INVALID = 5'h1E;
	localparam int STORE_DEPTH = 128;
	localparam int BUF_DEPTH = 8;
	localparam logic [3:0] SYNC_INIT = 4'h7;

	localparam int PW_NS [4] = '{14800, 29400, 58700, 117300};
	localparam int CNT_W = 14;

	function automatic int ns_to_cyc(input int ns);
		return (ns * CLK_MHZ + 999) / 1000;
	endfunction
endpackage

// >>> src/pin_sync.sv
// Purpose: two-flop synchroniser for pins sampled by mclk
// Assumes: levels only, one flop pair per bit
// Notes: INIT gives the idle level each bit shows in reset
`timescale 1ns/1ps
module pin_sync #(
	parameter int N = 1,
	parameter logic [N-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [N-1:0] d,
	output logic [N-1:0] q
);
	logic [N-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_q[i] <= INIT[i];
					q[i] <= INIT[i];
				end else begin
					meta_q[i] <= d[i];
					q[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule

// >>> src/stream_fifo.sv
// Purpose: valid/ready FIFO used as data buffer and result store
// Assumes: DEPTH is a power of two
// Notes: full stalls the writer through in_ready
`timescale 1ns/1ps
module stream_fifo #(
	parameter int W = 24,
	parameter int DEPTH = 8,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [CW-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rp_q];
	assign count = cnt_q;

	always_comb begin
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + CW'(push) - CW'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end
endmodule

// >>> sim/host_model.sv
// Purpose: host side of the two-wire register port
// Assumes: 80 ns bus clock, open-drain data line with pull-up
// Notes: sda_pull high means the host pulls the data line low
`timescale 1ns/1ps
module host_model
	import oes_pkg::*;
(
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	int nacks = 0;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Data moves mid-low, read back at the end of the high phase
	task automatic bitx(input logic w, output logic r);
		hw(2);
		sda_pull = ~w;
		hw(2);
		scl = 1'b1;
		hw(4);
		r = sda;
		scl = 1'b0;
	endtask
	// Serves as start and as repeated start
	task automatic start;
		hw(2);
		sda_pull = 1'b0;
		hw(2);
		scl = 1'b1;
		hw(4);
		sda_pull = 1'b1;
		hw(4);
		scl = 1'b0;
	endtask
	task automatic stop;
		hw(2);
		sda_pull = 1'b1;
		hw(2);
		scl = 1'b1;
		hw(4);
		sda_pull = 1'b0;
		hw(8);
	endtask
	task automatic wb(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(b[i], r);
		bitx(1'b1, r);
		if (r !== 1'b0)
			nacks++;
	endtask
	task automatic rb(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, b[i]);
		bitx(last, r);
	endtask
	task automatic wr(input logic [7:0] a, input int n,
		input logic [23:0] d);
		start();
		wb({DEV_ADDR, 1'b0});
		wb(a);
		for (int i = n - 1; i >= 0; i--)
			wb(d[8*i +: 8]);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, input int n,
		output logic [23:0] d);
		d = '0;
		start();
		wb({DEV_ADDR, 1'b0});
		wb(a);
		start();
		wb({DEV_ADDR, 1'b1});
		for (int i = n - 1; i >= 0; i--)
			rb(i == 0, d[8*i +: 8]);
		stop();
	endtask
endmodule

// >>> sim/tb.sv
// Purpose: self-checking bench of the optical exposure sequencer
// Assumes: GPIO sync mode paces samples, timer left at its default
// Notes: converter answers each request three cycles later
`timescale 1ns/1ps
module tb
	import oes_pkg::*;
;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic reg_en = 1'b1;
	logic gpio_low = 1'b0;
	logic adc_valid = 1'b0;
	logic [DATA_W-1:0] adc_data = '0;
	logic adc_picket = 1'b0;
	logic scl, sda_pull, sda_o, sda_oe, gpio_o, gpio_oe;
	logic [NUM_LEDS-1:0] led_on;
	logic [7:0] amp;
	logic [RANGE_W-1:0] rng;
	logic integrate, pilot, convert_req, power_down;
	wire sda = ~sda_pull & (sda_oe ? sda_o : 1'b1);
	wire gpio = ~gpio_low & (gpio_oe ? gpio_o : 1'b1);
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [3:0] obs_led [8];
	int obs_w [8];
	logic [9:0] obs_cur [8];
	int n_exp = 0;
	int w_cnt = 0;
	logic [DATA_W-1:0] dat_q [$];
	logic [DATA_W-1:0] adc_val = 19'h1_2345;
	logic pick = 1'b0;
	localparam int PW0 = PW_NS[0] * CLK_MHZ / 1000;
	localparam int PW3 = PW_NS[3] * CLK_MHZ / 1000;

	optical_exposure_sequencer i_optical_exposure_sequencer (
		.mclk(mclk), .resetn(resetn), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .gpio_i(gpio),
		.gpio_o(gpio_o), .gpio_oe(gpio_oe),
		.regulator_enable_input(reg_en), .led_on(led_on),
		.led_current_code(amp), .led_fullscale_range(rng),
		.integrate(integrate), .pilot(pilot),
		.convert_req(convert_req), .power_down(power_down),
		.adc_valid(adc_valid), .adc_data(adc_data),
		.adc_picket(adc_picket)
	);
	host_model i_host_model (.mclk(mclk), .sda(sda), .scl(scl),
		.sda_pull(sda_pull));

	initial forever #5 mclk = ~mclk;

	task automatic test_done;
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			num_errors++;
			test_done();
		end
	end
	// Records what lit and how long each exposure window lasted
	always @(negedge mclk) begin
		if (integrate === 1'b1) begin
			if (w_cnt == 0) begin
				obs_led[n_exp] <= {pilot, led_on};
				obs_cur[n_exp] <= {rng, amp};
			end
			w_cnt <= w_cnt + 1;
		end else if (w_cnt != 0) begin
			obs_w[n_exp] <= w_cnt;
			n_exp <= n_exp + 1;
			w_cnt <= 0;
		end
	end
	// Converter stand-in; data is scrambled once the pulse is over
	always @(negedge mclk)
		if (convert_req === 1'b1) begin
			repeat (3) @(negedge mclk);
			adc_valid = 1'b1;
			adc_data = adc_val;
			adc_picket = pick;
			dat_q.push_back(adc_val);
			adc_val = adc_val + 19'h0_1357;
			@(negedge mclk);
			adc_valid = 1'b0;
			adc_picket = 1'b0;
			adc_data = ~adc_data;
		end

	task automatic sample(input logic [23:0] s, input int n);
		int t;
		n_exp = 0;
		dat_q.delete();
		i_host_model.wr(A_SLOTS12, 3, s);
		@(negedge mclk);
		gpio_low = 1'b1;
		repeat (6400) @(negedge mclk);
		gpio_low = 1'b0;
		t = 0;
		while (dat_q.size() < n && t < 20000) begin
			@(negedge mclk);
			t++;
		end
		repeat (3000) @(negedge mclk);
		chk(n_exp, n);
		chk(dat_q.size(), n);
	endtask
	task automatic drain(input logic [39:0] tags, input int n);
		logic [23:0] v;
		i_host_model.rd(A_COUNT, 1, v);
		chk(v, n);
		for (int i = 0; i <= n; i++) begin
			i_host_model.rd(A_DATA, 3, v);
			if (i < n) begin
				chk(v[23:19], tags[5*i +: 5]);
				chk(v[18:0], dat_q[i]);
			end else
				chk(v, {TAG_INVALID, 19'h0_0000});
		end
	endtask
	task automatic run(input logic [23:0] s, input int n,
		input logic [31:0] leds, input logic [39:0] tags, input int w);
		sample(s, n);
		for (int i = 0; i < n; i++) begin
			chk(obs_led[i], leds[4*i +: 4]);
			chk(obs_w[i], w);
			case (leds[4*i +: 3])
				3'h1: chk(obs_cur[i], {2'h0, 8'h11});
				3'h2: chk(obs_cur[i], {2'h1, 8'h22});
				3'h4: chk(obs_cur[i], {2'h2, 8'h33});
				default: ;
			endcase
		end
		i_host_model.wr(A_GPIO_CFG, 1, 24'(GPIO_OUT));
		repeat (10) @(negedge mclk);
		chk(gpio_oe, n > 0);
		chk(gpio_o, 1'b0);
		drain(tags, n);
		repeat (10) @(negedge mclk);
		chk(gpio_oe, 1'b0);
		i_host_model.wr(A_GPIO_CFG, 1, 24'(GPIO_SYNC));
	endtask
	task automatic reg_test;
		logic [23:0] v;
		i_host_model.rd(A_SLOTS12, 3, v);
		chk(v, 24'h00_0000);
		i_host_model.rd(A_STATUS, 1, v);
		chk(v, 24'h00_0001);
		i_host_model.wr(A_SLOTS12, 3, 24'h5A_C3F1);
		i_host_model.rd(A_SLOTS12, 3, v);
		chk(v, 24'h5A_C3F1);
		i_host_model.wr(8'h30, 1, 24'h00_00FF);
		i_host_model.rd(8'h30, 1, v);
		chk(v, 24'h00_0000);
		i_host_model.wr(A_LED_AMP1, 3, 24'h11_2233);
		i_host_model.wr(A_LED_RANGE, 1, 24'h00_0024);
		chk(i_host_model.nacks, 0);
	endtask
	// Low power asked for only at 256 per second or slower
	task automatic power_test;
		i_host_model.wr(A_SAMPLE_CFG, 1, 24'h00_0010);
		repeat (50) @(negedge mclk);
		chk(power_down, 1'b0);
		i_host_model.wr(A_SAMPLE_CFG, 1, 24'h00_008F);
		repeat (50) @(negedge mclk);
		chk(power_down, 1'b1);
		i_host_model.wr(A_SAMPLE_CFG, 1, 24'(RST_SAMPLE_CFG));
	endtask
	task automatic off_test;
		logic [23:0] v;
		reg_en = 1'b0;
		repeat (5) @(negedge mclk);
		sample(24'h01_0000, 0);
		chk(led_on, 3'h0);
		reg_en = 1'b1;
		repeat (5) @(negedge mclk);
		i_host_model.rd(A_SLOTS12, 3, v);
		chk(v, 24'h01_0000);
		chk(i_host_model.nacks, 0);
	endtask

	initial begin
		repeat (20) @(negedge mclk);
		resetn = 1'b1;
		repeat (10) @(negedge mclk);
		reg_test();
		i_host_model.wr(A_GPIO_CFG, 1, 24'(GPIO_SYNC));
		power_test();
		run(24'h21_83A9, 5, {4'h0, 4'h9, 4'h4, 4'h2, 4'h1},
			{5'h05, TAG_PILOT, 5'h03, 5'h02, 5'h01}, PW0);
		pick = 1'b1;
		run(24'h32_0100, 3, {4'h1, 4'h4, 4'h2},
			{5'h0F, 5'h0E, 5'h0D}, PW0);
		pick = 1'b0;
		run(24'h01_0200, 1, 32'h0000_0001, 40'h01, PW0);
		run(24'h10_0000, 0, '0, '0, PW0);
		i_host_model.wr(A_SAMPLE_CFG, 1, 24'h00_006A);
		run(24'h09_0000, 1, '0, 40'h01, PW3);
		i_host_model.wr(A_SAMPLE_CFG, 1, 24'(RST_SAMPLE_CFG));
		off_test();
		test_done();
	end
endmodule
